// ==== pml_pkg.sv ====
// Constants, offsets and helpers for the programmable macrocell logic block.
// Assumes one clock domain; users reference every item as pml_pkg::name.
package pml_pkg;
	localparam int PML_NUM_CELLS = 10;
	localparam int PML_NUM_DED   = 12;
	localparam int PML_ARRAY_W   = 32;
	localparam int PML_MIN_TERMS = 8;
	localparam int PML_TERM_STEP = 2;
	localparam int PML_MAX_TERMS = 16;
	localparam int PML_PIN_W     = 24;
	// Array input positions
	localparam int PML_IO_POS    = 12;
	localparam int PML_FB_POS    = 22;
	// Synchronised pin vector positions
	localparam int PML_EXT_OE_POS = 22;
	localparam int PML_DCLK_POS   = 23;
	// Pin levels after reset: external enable starts released
	localparam logic [23:0] PML_PIN_RESET = 24'h40_0000;
	// Configuration bit positions
	localparam int PML_CFG_OE_SRC = 0;
	localparam int PML_CFG_REG    = 1;
	localparam int PML_CFG_POL    = 2;
	localparam int PML_CFG_FB     = 3;
	localparam logic [3:0] PML_CFG_RESET = 4'h0;
	// Register offsets
	localparam logic [11:0] PML_CTRL_OFS      = 12'h000;
	localparam logic [11:0] PML_PRELOAD_OFS   = 12'h004;
	localparam logic [11:0] PML_STATE_OFS     = 12'h008;
	localparam logic [11:0] PML_PINS_OFS      = 12'h00c;
	localparam logic [11:0] PML_PRESET_LO_OFS = 12'h010;
	localparam logic [11:0] PML_PRESET_HI_OFS = 12'h014;
	localparam logic [11:0] PML_RESET_LO_OFS  = 12'h018;
	localparam logic [11:0] PML_RESET_HI_OFS  = 12'h01c;
	localparam logic [3:0]  PML_CELL_BASE_HI  = 4'h4;
	localparam logic [4:0]  PML_OE_TERM_IDX   = 5'h10;
	localparam logic [5:0]  PML_CFG_WORD      = 6'h22;
	localparam int PML_CTRL_PRELOAD_BIT = 0;
	localparam logic [1:0] PML_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PML_RESP_SLVERR = 2'h2;

	// Term is true when any literal is connected and all connected ones hold
	function automatic logic term_hit(input logic [63:0] m, input logic [31:0] a);
		term_hit = (|m) && ((a & m[31:0]) == m[31:0]) && ((~a & m[63:32]) == m[63:32]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] k;
		k = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		merge = (old & ~k) | (d & k);
	endfunction
endpackage

// ==== pml_macrocell.sv ====
// One output macrocell: its product terms, enable term, mode bits and register.
// Assumes array inputs are already registered and all strobes are one-cycle pulses.
`timescale 1ns/1ps
module pml_macrocell #(
	parameter int NTERM = 8
) (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_ce,
	// Fuse write port
	input  wire logic        i_wr_en,
	input  wire logic [5:0]  i_wr_word,
	input  wire logic [31:0] i_wr_data,
	input  wire logic [3:0]  i_wr_strb,
	// Array and control
	input  wire logic [31:0] i_array,
	input  wire logic        i_ext_oe,
	input  wire logic        i_clk_pulse,
	input  wire logic        i_preset,
	input  wire logic        i_reset_term,
	input  wire logic        i_preload,
	input  wire logic        i_preload_bit,
	// Results
	output logic             o_fb,
	output logic             o_state,
	output logic             o_out,
	output logic             o_oe
);
	logic [63:0] term_r [NTERM];
	logic [63:0] oe_term_r;
	logic [3:0]  cfg_r;
	logic        q_r;
	logic        out_r;
	logic        oe_r;
	logic [NTERM-1:0] hit_w;
	wire  [4:0]  t_idx_w = i_wr_word[5:1];
	wire         hi_w    = i_wr_word[0];
	wire         oe_hit_w = pml_pkg::term_hit(oe_term_r, i_array);
	wire         sum_w   = |hit_w;
	wire         reg_w   = cfg_r[pml_pkg::PML_CFG_REG];
	wire         pol_w   = cfg_r[pml_pkg::PML_CFG_POL];

	for (genvar t = 0; t < NTERM; t++) begin : g_term
		assign hit_w[t] = pml_pkg::term_hit(term_r[t], i_array);
		always_ff @(posedge i_mclk or negedge i_reset_n) begin
			if (!i_reset_n) begin
				term_r[t] <= 64'h0;
			end else if (i_ce && i_wr_en && t_idx_w == 5'(t)) begin
				term_r[t][32*hi_w +: 32] <= pml_pkg::merge(term_r[t][32*hi_w +: 32],
					i_wr_data, i_wr_strb);
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			oe_term_r <= 64'h0;
			cfg_r     <= pml_pkg::PML_CFG_RESET;
		end else if (i_ce && i_wr_en) begin
			if (t_idx_w == pml_pkg::PML_OE_TERM_IDX)
				oe_term_r[32*hi_w +: 32] <= pml_pkg::merge(oe_term_r[32*hi_w +: 32],
					i_wr_data, i_wr_strb);
			if (i_wr_word == pml_pkg::PML_CFG_WORD && i_wr_strb[0])
				cfg_r <= i_wr_data[3:0];
		end
	end

	// Register: reset term first, then preload, then device clock edge
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q_r <= 1'b0;
		end else if (i_ce) begin
			if (i_reset_term)
				q_r <= 1'b0;
			else if (i_preload)
				q_r <= i_preload_bit;
			else if (i_clk_pulse)
				q_r <= i_preset | sum_w;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_r <= 1'b0;
			oe_r  <= 1'b0;
		end else if (i_ce) begin
			out_r <= pol_w ^ (reg_w ? q_r : sum_w);
			oe_r  <= cfg_r[pml_pkg::PML_CFG_OE_SRC] ? oe_hit_w : i_ext_oe;
		end
	end

	assign o_fb    = cfg_r[pml_pkg::PML_CFG_FB] ? q_r : sum_w;
	assign o_state = q_r;
	assign o_out   = out_r;
	assign o_oe    = oe_r;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	a_comb_polarity: assert property (i_ce && !reg_w |=> out_r == $past(pol_w ^ sum_w))
		else $error("combinatorial output wrong");
	a_reg_polarity: assert property (i_ce && reg_w |=> out_r == $past(pol_w ^ q_r))
		else $error("registered output wrong");
	a_oe_select: assert property (i_ce |=> oe_r == $past(cfg_r[0] ? oe_hit_w : i_ext_oe))
		else $error("enable source wrong");
	a_fb_select: assert property (o_fb == (cfg_r[3] ? q_r : sum_w))
		else $error("feedback source wrong");
endmodule

// ==== pml_top.sv ====
// Top of the programmable macrocell logic block with its AXI4-Lite fuse port.
// Assumes board pins are asynchronous to i_mclk and the device clock is slow.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module pml_top (
	// Clock, reset, enable
	input  wire logic        i_mclk,
	input  wire logic        i_reset_n,
	input  wire logic        i_ce,
	// AXI4-Lite write address
	input  wire logic [11:0] i_axi_awaddr,
	input  wire logic [2:0]  i_axi_awprot,
	input  wire logic        i_axi_awvalid,
	output logic             o_axi_awready,
	// AXI4-Lite write data and response
	input  wire logic [31:0] i_axi_wdata,
	input  wire logic [3:0]  i_axi_wstrb,
	input  wire logic        i_axi_wvalid,
	output logic             o_axi_wready,
	output logic [1:0]       o_axi_bresp,
	output logic             o_axi_bvalid,
	input  wire logic        i_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0] i_axi_araddr,
	input  wire logic [2:0]  i_axi_arprot,
	input  wire logic        i_axi_arvalid,
	output logic             o_axi_arready,
	output logic [31:0]      o_axi_rdata,
	output logic [1:0]       o_axi_rresp,
	output logic             o_axi_rvalid,
	input  wire logic        i_axi_rready,
	// Device pins
	input  wire logic [11:0] i_ded_in,
	input  wire logic        i_dev_clk,
	input  wire logic        i_ext_oe_n,
	input  wire logic [9:0]  i_io_in,
	output logic [9:0]       o_io_out,
	output logic [9:0]       o_io_oe
);
	localparam int NC = pml_pkg::PML_NUM_CELLS;
	localparam int PW = pml_pkg::PML_PIN_W;

	// Pin synchroniser and filter
	logic [PW-1:0] sync1_r;
	logic [PW-1:0] sync2_r;
	logic [PW-1:0] sync3_r;
	logic [PW-1:0] filt_r;
	logic          clk_pulse_r;
	wire  [PW-1:0] pins_w = {i_dev_clk, i_ext_oe_n, i_io_in, i_ded_in};
	wire  [PW-1:0] filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r ^ sync3_r));
	wire           dclk_rise_w = filt_nxt[pml_pkg::PML_DCLK_POS]
		& ~filt_r[pml_pkg::PML_DCLK_POS];

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_r     <= pml_pkg::PML_PIN_RESET;
			sync2_r     <= pml_pkg::PML_PIN_RESET;
			sync3_r     <= pml_pkg::PML_PIN_RESET;
			filt_r      <= pml_pkg::PML_PIN_RESET;
			clk_pulse_r <= 1'b0;
		end else if (i_ce) begin
			sync1_r     <= pins_w;
			sync2_r     <= sync1_r;
			sync3_r     <= sync2_r;
			filt_r      <= filt_nxt;
			clk_pulse_r <= dclk_rise_w;
		end
	end

	// Array inputs: dedicated pins, I/O pins, macrocell feedback
	logic [31:0]   array_r;
	logic [NC-1:0] fb_w;
	logic [NC-1:0] state_w;
	logic [NC-1:0] out_w;
	logic [NC-1:0] oe_w;
	wire  [31:0]   array_nxt = {fb_w, filt_r[21:0]};

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n)
			array_r <= 32'h0;
		else if (i_ce)
			array_r <= array_nxt;
	end

	// Shared control terms
	logic [63:0]   preset_term_r;
	logic [63:0]   reset_term_r;
	logic [NC-1:0] preload_data_r;
	logic          preload_go_r;
	wire           preset_hit_w = pml_pkg::term_hit(preset_term_r, array_r);
	wire           reset_hit_w  = pml_pkg::term_hit(reset_term_r, array_r);
	wire           ext_oe_w     = ~filt_r[pml_pkg::PML_EXT_OE_POS];

	// AXI write channel state
	logic          aw_full_r;
	logic [11:0]   aw_addr_r;
	logic          w_full_r;
	logic [31:0]   w_data_r;
	logic [3:0]    w_strb_r;
	logic          awready_r;
	logic          wready_r;
	logic          bvalid_r;
	logic [1:0]    bresp_r;
	wire           aw_hs_w  = i_axi_awvalid & awready_r;
	wire           w_hs_w   = i_axi_wvalid & wready_r;
	wire           do_wr_w  = aw_full_r & w_full_r & ~bvalid_r;
	wire           aw_full_nxt = ~do_wr_w & (aw_full_r | aw_hs_w);
	wire           w_full_nxt  = ~do_wr_w & (w_full_r | w_hs_w);

	// Write decode
	wire           wr_top_w  = aw_addr_r[11:5] == 7'h0;
	wire  [3:0]    wr_cell_w = aw_addr_r[11:8] - pml_pkg::PML_CELL_BASE_HI;
	wire  [5:0]    wr_word_w = aw_addr_r[7:2];
	wire           wr_cell_ok_w = aw_addr_r[11:8] >= pml_pkg::PML_CELL_BASE_HI
		&& wr_cell_w < 4'(NC) && wr_word_w <= pml_pkg::PML_CFG_WORD;
	wire           wr_ok_w   = wr_top_w | wr_cell_ok_w;
	wire           wr_at_w   = do_wr_w & wr_top_w;
	wire           wr_ctrl_w = wr_at_w && aw_addr_r == pml_pkg::PML_CTRL_OFS;
	wire           wr_pre_w  = wr_at_w && aw_addr_r == pml_pkg::PML_PRELOAD_OFS;
	wire           wr_psl_w  = wr_at_w && aw_addr_r == pml_pkg::PML_PRESET_LO_OFS;
	wire           wr_psh_w  = wr_at_w && aw_addr_r == pml_pkg::PML_PRESET_HI_OFS;
	wire           wr_rsl_w  = wr_at_w && aw_addr_r == pml_pkg::PML_RESET_LO_OFS;
	wire           wr_rsh_w  = wr_at_w && aw_addr_r == pml_pkg::PML_RESET_HI_OFS;
	wire           preload_nxt = wr_ctrl_w & w_strb_r[0]
		& w_data_r[pml_pkg::PML_CTRL_PRELOAD_BIT];
	wire  [31:0]   pre_merge_w = pml_pkg::merge({22'h0, preload_data_r}, w_data_r, w_strb_r);

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
		end else if (i_ce) begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awready_r <= ~aw_full_nxt;
			wready_r  <= ~w_full_nxt;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			aw_addr_r <= 12'h000;
			w_data_r  <= 32'h0;
			w_strb_r  <= 4'h0;
		end else if (i_ce) begin
			if (aw_hs_w)
				aw_addr_r <= {i_axi_awaddr[11:2], 2'h0};
			if (w_hs_w) begin
				w_data_r <= i_axi_wdata;
				w_strb_r <= i_axi_wstrb;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bvalid_r <= 1'b0;
			bresp_r  <= pml_pkg::PML_RESP_OKAY;
		end else if (i_ce) begin
			if (do_wr_w) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_ok_w ? pml_pkg::PML_RESP_OKAY : pml_pkg::PML_RESP_SLVERR;
			end else if (i_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Shared term masks, preload data and preload strobe
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			preset_term_r  <= 64'h0;
			reset_term_r   <= 64'h0;
			preload_data_r <= '0;
			preload_go_r   <= 1'b0;
		end else if (i_ce) begin
			if (wr_psl_w)
				preset_term_r[31:0] <= pml_pkg::merge(preset_term_r[31:0], w_data_r, w_strb_r);
			if (wr_psh_w)
				preset_term_r[63:32] <= pml_pkg::merge(preset_term_r[63:32], w_data_r, w_strb_r);
			if (wr_rsl_w)
				reset_term_r[31:0] <= pml_pkg::merge(reset_term_r[31:0], w_data_r, w_strb_r);
			if (wr_rsh_w)
				reset_term_r[63:32] <= pml_pkg::merge(reset_term_r[63:32], w_data_r, w_strb_r);
			if (wr_pre_w)
				preload_data_r <= pre_merge_w[NC-1:0];
			preload_go_r <= preload_nxt;
		end
	end

	// AXI read channel
	logic          arready_r;
	logic          rvalid_r;
	logic [31:0]   rdata_r;
	logic [1:0]    rresp_r;
	wire           ar_hs_w    = i_axi_arvalid & arready_r;
	wire  [11:0]   ra_w       = {i_axi_araddr[11:2], 2'h0};
	wire           rd_top_w   = ra_w[11:5] == 7'h0;
	wire  [3:0]    rd_cell_w  = ra_w[11:8] - pml_pkg::PML_CELL_BASE_HI;
	wire           rd_cell_ok_w = ra_w[11:8] >= pml_pkg::PML_CELL_BASE_HI
		&& rd_cell_w < 4'(NC) && ra_w[7:2] <= pml_pkg::PML_CFG_WORD;
	wire  [31:0]   rd_mux_w =
		ra_w == pml_pkg::PML_PRELOAD_OFS   ? {22'h0, preload_data_r} :
		ra_w == pml_pkg::PML_STATE_OFS     ? {12'h0, oe_w, state_w} :
		ra_w == pml_pkg::PML_PINS_OFS      ? {8'h0, filt_r} :
		ra_w == pml_pkg::PML_PRESET_LO_OFS ? preset_term_r[31:0] :
		ra_w == pml_pkg::PML_PRESET_HI_OFS ? preset_term_r[63:32] :
		ra_w == pml_pkg::PML_RESET_LO_OFS  ? reset_term_r[31:0] :
		ra_w == pml_pkg::PML_RESET_HI_OFS  ? reset_term_r[63:32] : 32'h0;
	wire           rd_ok_w   = rd_top_w | rd_cell_ok_w;
	wire           rvalid_nxt = ar_hs_w | (rvalid_r & ~i_axi_rready);

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0;
			rresp_r   <= pml_pkg::PML_RESP_OKAY;
		end else if (i_ce) begin
			arready_r <= ~rvalid_nxt;
			rvalid_r  <= rvalid_nxt;
			if (ar_hs_w) begin
				rdata_r <= rd_top_w ? rd_mux_w : 32'h0;
				rresp_r <= rd_ok_w ? pml_pkg::PML_RESP_OKAY : pml_pkg::PML_RESP_SLVERR;
			end
		end
	end

	// Macrocells with term counts rising by pairs
	for (genvar m = 0; m < NC; m++) begin : g_cell
		localparam int NT = pml_pkg::PML_MIN_TERMS + pml_pkg::PML_TERM_STEP * (m / 2);
		wire cell_wr_w = do_wr_w & wr_cell_ok_w & (wr_cell_w == 4'(m));
		pml_macrocell #(
			.NTERM(NT)
		) u_cell (
			.i_mclk        (i_mclk),
			.i_reset_n     (i_reset_n),
			.i_ce          (i_ce),
			.i_wr_en       (cell_wr_w),
			.i_wr_word     (wr_word_w),
			.i_wr_data     (w_data_r),
			.i_wr_strb     (w_strb_r),
			.i_array       (array_r),
			.i_ext_oe      (ext_oe_w),
			.i_clk_pulse   (clk_pulse_r),
			.i_preset      (preset_hit_w),
			.i_reset_term  (reset_hit_w),
			.i_preload     (preload_go_r),
			.i_preload_bit (preload_data_r[m]),
			.o_fb          (fb_w[m]),
			.o_state       (state_w[m]),
			.o_out         (out_w[m]),
			.o_oe          (oe_w[m])
		);
	end

	assign o_axi_awready = awready_r;
	assign o_axi_wready  = wready_r;
	assign o_axi_bvalid  = bvalid_r;
	assign o_axi_bresp   = bresp_r;
	assign o_axi_arready = arready_r;
	assign o_axi_rvalid  = rvalid_r;
	assign o_axi_rdata   = rdata_r;
	assign o_axi_rresp   = rresp_r;
	assign o_io_out      = out_w;
	assign o_io_oe       = oe_w;

	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	sequence s_preset_edge;
		i_ce && clk_pulse_r && preset_hit_w && !reset_hit_w && !preload_go_r;
	endsequence
	sequence s_preload_req;
		i_ce && preload_go_r && !reset_hit_w;
	endsequence
	sequence s_preload_cmd;
		i_ce && preload_nxt ##1 i_ce && !reset_hit_w;
	endsequence

	a_reset_term_clear: assert property (i_ce && reset_hit_w |=> state_w == '0)
		else $error("reset term did not clear registers");
	a_powerup_zero: assert property ($rose(i_reset_n) |-> state_w == '0)
		else $error("registers not zero after power-up");
	a_preset_sets: assert property (s_preset_edge |=> state_w == '1)
		else $error("preset term did not set registers");
	a_preload_loads: assert property (s_preload_req |=> state_w == $past(preload_data_r))
		else $error("preload value not loaded");
	a_preload_cmd: assert property (s_preload_cmd |=> state_w == $past(preload_data_r))
		else $error("control write did not preload");
	a_state_hold: assert property (!clk_pulse_r && !preload_go_r && !reset_hit_w
		|=> $stable(state_w))
		else $error("register moved without device clock");
	a_pin_sense: assert property (i_ce |=> array_r[21:12] == $past(filt_r[21:12]))
		else $error("pin level not sensed by array");
	a_fb_path: assert property (i_ce |=> array_r[31:22] == $past(fb_w))
		else $error("macrocell feedback not in array");
	a_bvalid_hold: assert property (bvalid_r && !i_axi_bready |=> bvalid_r)
		else $error("write response dropped");

	sequence s_read_taken;
		i_ce && ar_hs_w;
	endsequence
	sequence s_write_done;
		i_ce && do_wr_w;
	endsequence

	a_read_answer: assert property (s_read_taken |=> rvalid_r && !arready_r)
		else $error("read answer late");
	a_read_refused: assert property (s_read_taken ##0 !rd_ok_w
		|=> rdata_r == 32'h0 && rresp_r == pml_pkg::PML_RESP_SLVERR)
		else $error("unmapped read not refused");
	a_read_release: assert property (i_ce && rvalid_r && i_axi_rready |=> !rvalid_r && arready_r)
		else $error("read slot not freed");
	a_write_answer: assert property (s_write_done |=> bvalid_r && awready_r && wready_r)
		else $error("write answer late");
	a_write_refused: assert property (s_write_done ##0 !wr_ok_w
		|=> bresp_r == pml_pkg::PML_RESP_SLVERR)
		else $error("unmapped write not refused");
	a_write_slot: assert property (i_ce && aw_hs_w |=> !awready_r)
		else $error("address slot not closed");
	a_bvalid_clear: assert property (i_ce && bvalid_r && i_axi_bready |=> !bvalid_r)
		else $error("write response not cleared");
	a_pulse_once: assert property (i_ce && clk_pulse_r |=> !clk_pulse_r)
		else $error("device clock pulse too long");
	a_dclk_pulse: assert property (i_ce && !filt_r[pml_pkg::PML_DCLK_POS]
		##1 filt_r[pml_pkg::PML_DCLK_POS] |-> clk_pulse_r)
		else $error("device clock edge missed");
	a_filter_agree: assert property (i_ce && sync2_r == sync3_r |=> filt_r == $past(sync2_r))
		else $error("agreed pin level not taken");
	a_ce_freeze: assert property (!i_ce
		|=> $stable(state_w) && $stable(oe_w) && $stable(array_r))
		else $error("state moved while frozen");
	a_state_read: assert property (s_read_taken ##0 ra_w == pml_pkg::PML_STATE_OFS
		|=> rdata_r[9:0] == $past(state_w))
		else $error("state read wrong");
	a_pins_read: assert property (s_read_taken ##0 ra_w == pml_pkg::PML_PINS_OFS
		|=> rdata_r == {8'h0, $past(filt_r)})
		else $error("pin read wrong");
	a_preload_read: assert property (s_read_taken ##0 ra_w == pml_pkg::PML_PRELOAD_OFS
		|=> rdata_r == {22'h0, $past(preload_data_r)})
		else $error("preload read wrong");
endmodule

// ==== pml_board.sv ====
// Board-side partner: resolves the ten I/O wires from device and board drive.
// Assumes the bench asks for board drive only on pins it uses as inputs.
`timescale 1ns/1ps
module pml_board (
	// Clock
	input  wire logic       i_mclk,
	// Device drive
	input  wire logic [9:0] i_io_out,
	input  wire logic [9:0] i_io_oe,
	// Board drive
	input  wire logic [9:0] i_brd_val,
	input  wire logic [9:0] i_brd_en,
	// Wire levels
	output logic      [9:0] o_io_in
);
	logic [9:0] last_r = 10'h000;
	// Device drive wins; released wires show the inverse of their last level
	assign o_io_in = (i_io_oe & i_io_out) | (~i_io_oe & i_brd_en & i_brd_val)
		| (~i_io_oe & ~i_brd_en & ~last_r);
	always @(posedge i_mclk) begin
		last_r <= ((i_io_oe | i_brd_en) & o_io_in) | (~(i_io_oe | i_brd_en) & last_r);
	end
endmodule

// ==== testbench.sv ====
// Self-checking bench for the macrocell logic block through its AXI4-Lite port.
// Assumes pml_top and pml_board; read and write answers are checked from queues.
`timescale 1ns/1ps
module testbench;
	localparam logic [1:0]  OKAY = pml_pkg::PML_RESP_OKAY;
	localparam logic [1:0]  ERR  = pml_pkg::PML_RESP_SLVERR;
	localparam logic [11:0] CT   = pml_pkg::PML_CTRL_OFS;
	localparam logic [11:0] PL   = pml_pkg::PML_PRELOAD_OFS;
	localparam logic [11:0] ST   = pml_pkg::PML_STATE_OFS;
	localparam logic [11:0] PS   = pml_pkg::PML_PINS_OFS;
	logic        i_mclk, i_reset_n, i_dev_clk, i_ext_oe_n, pol, regd, ce;
	logic        i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready;
	logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
	logic [1:0]  o_axi_bresp, o_axi_rresp;
	logic [11:0] i_axi_awaddr, i_axi_araddr, i_ded_in;
	logic [31:0] i_axi_wdata, o_axi_rdata;
	logic [9:0]  i_io_in, o_io_out, o_io_oe, brd_val, brd_en, pre;
	logic [31:0] exp_q[$], msk_q[$];
	logic [1:0]  rsp_q[$], bsp_q[$];
	int          mismatches, compares;

	pml_top pml_top_i (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(ce),
		.i_axi_awaddr(i_axi_awaddr), .i_axi_awprot(3'h0), .i_axi_awvalid(i_axi_awvalid),
		.o_axi_awready(o_axi_awready), .i_axi_wdata(i_axi_wdata), .i_axi_wstrb(4'hf),
		.i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .o_axi_bresp(o_axi_bresp),
		.o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready), .i_axi_araddr(i_axi_araddr),
		.i_axi_arprot(3'h0), .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready),
		.o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp), .o_axi_rvalid(o_axi_rvalid),
		.i_axi_rready(i_axi_rready), .i_ded_in(i_ded_in), .i_dev_clk(i_dev_clk),
		.i_ext_oe_n(i_ext_oe_n), .i_io_in(i_io_in), .o_io_out(o_io_out), .o_io_oe(o_io_oe)
	);
	pml_board pml_board_i (
		.i_mclk(i_mclk), .i_io_out(o_io_out), .i_io_oe(o_io_oe),
		.i_brd_val(brd_val), .i_brd_en(brd_en), .o_io_in(i_io_in)
	);

	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp_data(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmp_resp(input string what, input logic [1:0] e, input logic [1:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_mclk);
	endtask
	task automatic dclk;
		i_dev_clk <= 1'b1;
		tick(8);
		i_dev_clk <= 1'b0;
		tick(8);
	endtask
	function automatic logic [11:0] fuse(input int m, input int w);
		fuse = 12'h400 + 12'(m * 256 + w * 4);
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ap, wp, bs;
		int n;
		ap = 1'b1;
		wp = 1'b1;
		bs = 1'b0;
		n = 0;
		bsp_q.push_back(r);
		i_axi_awaddr <= a;
		i_axi_wdata <= d;
		i_axi_awvalid <= 1'b1;
		i_axi_wvalid <= 1'b1;
		i_axi_bready <= 1'b1;
		while (!bs && n < 200) begin
			@(posedge i_mclk);
			n++;
			if (o_axi_bvalid === 1'b1) bs = 1'b1;
			if (o_axi_awready === 1'b1) ap = 1'b0;
			if (o_axi_wready === 1'b1) wp = 1'b0;
			if (!ap) i_axi_awvalid <= 1'b0;
			if (!wp) i_axi_wvalid <= 1'b0;
		end
		i_axi_bready <= 1'b0;
		if (!bs) cmp_resp("handshake", 2'h0, 2'h3);
		@(posedge i_mclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r);
		logic ap, rs;
		int n;
		ap = 1'b1;
		rs = 1'b0;
		n = 0;
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		rsp_q.push_back(r);
		i_axi_araddr <= a;
		i_axi_arvalid <= 1'b1;
		i_axi_rready <= 1'b1;
		while (!rs && n < 200) begin
			@(posedge i_mclk);
			n++;
			if (o_axi_rvalid === 1'b1) rs = 1'b1;
			if (o_axi_arready === 1'b1) ap = 1'b0;
			if (!ap) i_axi_arvalid <= 1'b0;
		end
		i_axi_rready <= 1'b0;
		if (!rs) cmp_resp("handshake", 2'h0, 2'h3);
		@(posedge i_mclk);
	endtask

	// Answer monitor: oldest note against each answer
	always @(posedge i_mclk) begin
		if (o_axi_rvalid === 1'b1 && i_axi_rready === 1'b1 && exp_q.size() > 0) begin
			cmp_data("rdata", exp_q.pop_front(), o_axi_rdata & msk_q.pop_front());
			cmp_resp("rresp", rsp_q.pop_front(), o_axi_rresp);
		end
		if (o_axi_bvalid === 1'b1 && i_axi_bready === 1'b1 && bsp_q.size() > 0)
			cmp_resp("bresp", bsp_q.pop_front(), o_axi_bresp);
	end
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	initial begin
		#200000;
		mismatches++;
		complete_run;
	end
	initial begin
		i_reset_n = 1'b0;
		i_ext_oe_n = 1'b1;
		ce = 1'b1;
		{i_dev_clk, i_axi_awvalid, i_axi_wvalid, i_axi_bready, i_axi_arvalid, i_axi_rready} = '0;
		{i_axi_awaddr, i_axi_araddr, i_ded_in, i_axi_wdata, brd_val, brd_en} = '0;
		mismatches = 0;
		compares = 0;
		void'($urandom(84));
		tick(6);
		i_reset_n <= 1'b1;
		tick(2);
		// Reset state and bus refusals
		rd(ST, 32'h0, 32'h000f_ffff, OKAY);
		rd(12'h300, 32'h0, 32'hffff_ffff, ERR);
		wr(12'h300, 32'h1, ERR);
		rd(fuse(0, 0), 32'h0, 32'hffff_ffff, OKAY);
		// Last term of every cell, one past it on cell 0
		for (int m = 0; m < 10; m++) wr(fuse(m, 2 * (7 + 2 * (m / 2))), 32'h10, OKAY);
		wr(fuse(0, 16), 32'h20, OKAY);
		i_ext_oe_n <= 1'b0;
		i_ded_in <= 12'h010;
		tick(12);
		rd(PS, 32'h003f_f010, 32'h00ff_ffff, OKAY);
		i_ded_in <= 12'h020;
		tick(12);
		rd(PS, 32'h0000_0020, 32'h00ff_ffff, OKAY);
		// All four modes of cell 0
		wr(fuse(0, 0), 32'h1, OKAY);
		for (int md = 0; md < 4; md++) begin
			pol = md[0];
			regd = md[1];
			wr(fuse(0, 34), 32'((md & 2) | ((md & 1) << 2)), OKAY);
			wr(PL, 32'h0, OKAY);
			wr(CT, 32'h1, OKAY);
			i_ded_in <= 12'h001;
			tick(12);
			rd(PS, {19'h0, regd ? pol : ~pol, 12'h0}, 32'h1000, OKAY);
			dclk;
			rd(PS, {19'h0, ~pol, 12'h0}, 32'h1000, OKAY);
			rd(ST, 32'h401, 32'h401, OKAY);
		end
		i_ext_oe_n <= 1'b1;
		tick(12);
		rd(ST, 32'h0, 32'hffc00, OKAY);
		i_ext_oe_n <= 1'b0;
		// Enable from the cell's own term
		wr(fuse(0, 34), 32'h1, OKAY);
		wr(fuse(0, 32), 32'h8, OKAY);
		i_ded_in <= 12'h008;
		tick(12);
		rd(ST, 32'hffc00, 32'hffc00, OKAY);
		i_ded_in <= 12'h000;
		tick(12);
		rd(ST, 32'hff800, 32'hffc00, OKAY);
		// Buried register behind an input pin, fed back to cell 2
		wr(fuse(1, 0), 32'h2000, OKAY);
		wr(fuse(1, 34), 32'hb, OKAY);
		wr(fuse(2, 0), 32'h0080_0000, OKAY);
		brd_en <= 10'h002;
		brd_val <= 10'h002;
		tick(12);
		dclk;
		rd(ST, 32'h002, 32'h802, OKAY);
		rd(PS, 32'h6000, 32'h6000, OKAY);
		brd_val <= 10'h000;
		tick(12);
		rd(PS, 32'h4000, 32'h6000, OKAY);
		wr(fuse(1, 34), 32'h3, OKAY);
		tick(12);
		rd(PS, 32'h0, 32'h4000, OKAY);
		// Shared preset and reset terms
		wr(pml_pkg::PML_PRESET_LO_OFS, 32'h2, OKAY);
		i_ded_in <= 12'h002;
		tick(12);
		dclk;
		rd(ST, 32'h3ff, 32'h3ff, OKAY);
		wr(pml_pkg::PML_RESET_LO_OFS, 32'h4, OKAY);
		i_ded_in <= 12'h004;
		tick(12);
		rd(ST, 32'h0, 32'h3ff, OKAY);
		i_ded_in <= 12'h000;
		tick(12);
		// Frozen block ignores a preset edge
		ce <= 1'b0;
		i_ded_in <= 12'h002;
		dclk;
		i_ded_in <= 12'h000;
		ce <= 1'b1;
		tick(12);
		rd(ST, 32'h0, 32'h3ff, OKAY);
		// Random preload, buried cell included
		repeat (3) begin
			pre = 10'($urandom);
			wr(PL, {22'h0, pre}, OKAY);
			rd(PL, {22'h0, pre}, 32'h3ff, OKAY);
			wr(CT, 32'h1, OKAY);
			rd(ST, {22'h0, pre}, 32'h3ff, OKAY);
		end
		complete_run;
	end
endmodule
